// *** common/fcu_pkg.sv ***
/*
 * Constants, types and decode helpers of the float/integer conversion unit.
 * Assumes the consumer imports the whole package.
 */
package fcu_pkg;
    // Bus and register file geometry.
    localparam int FCU_AW = 8;
    localparam int FCU_DW = 32;
    localparam int FCU_RIW = 3;
    localparam int FCU_NREG = 8;
    // Register byte offsets.
    localparam logic [7:0] FCU_INSTR_OFS = 8'h00;
    localparam logic [7:0] FCU_STATUS_OFS = 8'h04;
    localparam logic [7:0] FCU_FLAGS_OFS = 8'h08;
    localparam logic [7:0] FCU_FPREG_BASE = 8'h20;
    localparam logic [7:0] FCU_FPREG_MASK = 8'he0;
    // Status fields.
    localparam int FCU_ST_BUSY_BIT = 0;
    localparam int FCU_ST_ILL_BIT = 1;
    // Status flags: test, integer zero/negative, float zero/negative, latched under/overflow.
    localparam int FCU_FLAGS_W = 7;
    localparam logic [6:0] FCU_FLAGS_RST = 7'h00;
    localparam logic [31:0] FCU_WORD_RST = 32'h0000_0000;
    // Instruction fields: low word in 15:0, high word in 31:16.
    localparam logic [15:0] FCU_LSW_S16 = 16'he68c;
    localparam logic [15:0] FCU_LSW_S32 = 16'he688;
    localparam logic [15:0] FCU_LSW_U16 = 16'he68e;
    localparam logic [15:0] FCU_LSW_U32 = 16'he68a;
    localparam logic [15:0] FCU_LSW_FRAC = 16'he6f1;
    localparam logic [15:0] FCU_LSW_I2F = 16'he68d;
    localparam int FCU_MSW_RND_BIT = 15;
    localparam int FCU_MSW_SRC_LSB = 3;
    localparam int FCU_MSW_DST_LSB = 0;
    localparam int FCU_PIPE_CYCLES = 2;
    // Single-precision exponent landmarks.
    localparam logic [7:0] FCU_EXP_BIAS = 8'h7f;
    localparam logic [7:0] FCU_EXP_FIX0 = 8'h76;
    localparam logic [7:0] FCU_EXP_INT = 8'h96;
    localparam logic [7:0] FCU_EXP_MAX = 8'h9e;
    localparam int FCU_FRAC_W = 32;

    // Conversion operations.
    typedef enum logic [3:0] {
        fcu_op_none, float_to_s16_trunc_op, float_to_s16_round_op, float_to_s32_trunc_op,
        float_to_u16_trunc_op, float_to_u16_round_op, float_to_u32_op,
        fraction_extract_op, s16_to_float_op
    } fcu_op_type;

    // Decodes a register-to-register conversion word; unknown words give none.
    function automatic fcu_op_type fcu_decode(input logic [31:0] w);
        logic rnd;
        fcu_op_type r;
        rnd = w[16 + FCU_MSW_RND_BIT];
        r = fcu_op_none;
        if (w[30:22] == 9'h000) begin
            unique case (w[15:0])
                FCU_LSW_S16: r = rnd ? float_to_s16_round_op : float_to_s16_trunc_op;
                FCU_LSW_U16: r = rnd ? float_to_u16_round_op : float_to_u16_trunc_op;
                FCU_LSW_S32: r = rnd ? fcu_op_none : float_to_s32_trunc_op;
                FCU_LSW_U32: r = rnd ? fcu_op_none : float_to_u32_op;
                FCU_LSW_FRAC: r = rnd ? fcu_op_none : fraction_extract_op;
                FCU_LSW_I2F: r = rnd ? fcu_op_none : s16_to_float_op;
                default: r = fcu_op_none;
            endcase
        end
        return r;
    endfunction

    // Position of the highest set bit, zero for an empty word.
    function automatic logic [4:0] fcu_lead_one(input logic [31:0] v);
        logic [4:0] p;
        p = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                p = 5'(i);
            end
        end
        return p;
    endfunction
endpackage

// *** hdl/fcu_regfile.sv ***
/*
 * Eight-word floating-point register file with one write and one read port.
 * Assumes callers allow one cycle for read data, which comes from a register.
 */
`timescale 1ns/1ns
`default_nettype none
module fcu_regfile
    import fcu_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire logic              i_clk_en,
    // Write port.
    input  wire logic              i_we,
    input  wire logic [2:0]        i_waddr,
    input  wire logic [31:0]       i_wdata,
    // Read port.
    input  wire logic [2:0]        i_raddr,
    output logic      [31:0]       o_rdata
);
    logic [31:0] mem [FCU_NREG];      // Register contents.
    logic [31:0] next_mem [FCU_NREG]; // Contents after this cycle.
    logic [31:0] next_rdata;          // Read data after this cycle.

    // A read in the cycle of a write returns the old contents.
    always_comb begin
        next_mem = mem;
        next_rdata = mem[i_raddr];
        if (i_we) begin
            next_mem[i_waddr] = i_wdata;
        end
    end

    // Registers the array and the read word.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < FCU_NREG; i++) begin
                mem[i] <= FCU_WORD_RST;
            end
            o_rdata <= FCU_WORD_RST;
        end else if (i_clk_en) begin
            mem <= next_mem;
            o_rdata <= next_rdata;
        end
    end
endmodule // fcu_regfile
`default_nettype wire

// *** hdl/fcu_convert.sv ***
/*
 * Combinational conversion datapath: float to integer, fraction, int16 to float.
 * Assumes denormal inputs count as zero and out-of-range values saturate.
 */
`timescale 1ns/1ns
`default_nettype none
module fcu_convert
    import fcu_pkg::*;
(
    // Operation and source word.
    input  wire fcu_op_type        i_op,
    input  wire logic [31:0]       i_src,
    // Result word.
    output logic      [31:0]       o_result
);
    logic        sgn;      // Source sign.
    logic [7:0]  ex;       // Source exponent.
    logic        zero_in;  // Zero or denormal source.
    logic        big;      // Magnitude beyond 32 integer bits.
    logic [71:0] fx;       // Magnitude with 32 fraction bits.
    logic [39:0] ipart;    // Integer part of the magnitude.
    logic [31:0] frac;     // Fraction part of the magnitude.
    logic [39:0] mag;      // Truncated or rounded magnitude.
    logic        rnd;      // Rounding requested.
    logic [4:0]  lp;       // Leading one of the fraction part.
    logic [31:0] tf;       // Normalised fraction.
    logic [15:0] m16;      // Magnitude of the 16-bit integer.
    logic [23:0] t16;      // Normalised 16-bit magnitude.

    always_comb begin
        sgn = i_src[31];
        ex = i_src[30:23];
        zero_in = (ex == 8'h00);
        big = (ex > FCU_EXP_MAX);
        fx = '0;
        // Aligning the mantissa to a fixed point makes every form one shift.
        if (!zero_in && !big) begin
            if (ex >= FCU_EXP_FIX0) begin
                fx = 72'({1'b1, i_src[22:0]}) << (ex - FCU_EXP_FIX0);
            end else begin
                fx = 72'({1'b1, i_src[22:0]}) >> (FCU_EXP_FIX0 - ex);
            end
        end
        ipart = fx[71:32];
        frac = fx[31:0];
        rnd = (i_op == float_to_s16_round_op) || (i_op == float_to_u16_round_op);
        mag = ipart;
        if (rnd && frac[31] && ((|frac[30:0]) || ipart[0])) begin
            mag = ipart + 40'h1;
        end
        if (big) begin
            mag = '1;
        end
        lp = fcu_lead_one(frac);
        tf = frac << (5'h1f - lp);
        m16 = i_src[15] ? 16'(-i_src[15:0]) : i_src[15:0];
        t16 = 24'({m16, 8'h00}) << (5'h0f - fcu_lead_one({16'h0000, m16}));
        o_result = '0;
        unique case (i_op)
            float_to_s16_trunc_op, float_to_s16_round_op: begin
                // Results saturate to the signed 16-bit range.
                if (sgn) begin
                    o_result[15:0] = (mag > 40'h8000) ? 16'h8000 : 16'(-mag[15:0]);
                end else begin
                    o_result[15:0] = (mag > 40'h7fff) ? 16'h7fff : mag[15:0];
                end
                o_result[31:16] = {16{o_result[15]}};
            end
            float_to_s32_trunc_op: begin
                if (sgn) begin
                    o_result = (mag > 40'h8000_0000) ? 32'h8000_0000 : 32'(-mag[31:0]);
                end else begin
                    o_result = (mag > 40'h7fff_ffff) ? 32'h7fff_ffff : mag[31:0];
                end
            end
            float_to_u16_trunc_op, float_to_u16_round_op: begin
                // The upper half stays zero.
                if (!sgn) begin
                    o_result[15:0] = (mag > 40'hffff) ? 16'hffff : mag[15:0];
                end
            end
            float_to_u32_op: begin
                // Negative sources leave the zero in place.
                if (!sgn) begin
                    o_result = (mag > 40'hffff_ffff) ? 32'hffff_ffff : mag[31:0];
                end
            end
            fraction_extract_op: begin
                // Sources below one are their own fraction.
                if (!zero_in && ex < FCU_EXP_BIAS) begin
                    o_result = i_src;
                end else if (!zero_in && ex < FCU_EXP_INT && frac != 32'h0) begin
                    o_result = {sgn, 8'(FCU_EXP_BIAS - 8'(FCU_FRAC_W)) + {3'h0, lp}, tf[30:8]};
                end
            end
            s16_to_float_op: begin
                // Zero stays the all-zero word.
                if (m16 != 16'h0) begin
                    o_result = {i_src[15], FCU_EXP_BIAS + {3'h0, fcu_lead_one({16'h0, m16})},
                                t16[22:0]};
                end
            end
            default: o_result = '0;
        endcase
    end
endmodule // fcu_convert
`default_nettype wire

// *** hdl/fcu_top.sv ***
/*
 * Conversion unit top: APB slave, instruction issue, two-stage pipeline.
 * Assumes an APB master that keeps requests stable until pready is sampled.
 */
`timescale 1ns/1ns
`default_nettype none
module fcu_top
    import fcu_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire logic              i_clk_en,
    // APB request.
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [7:0]        i_paddr,
    input  wire logic [31:0]       i_pwdata,
    // APB answer.
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr
);
    // Pipeline stage.
    typedef enum logic [1:0] {fcu_st_idle, fcu_st_read, fcu_st_write} fcu_st_type;

    localparam int PIPE_LAT = FCU_PIPE_CYCLES;

    fcu_st_type  st, next_st;              // Pipeline stage.
    fcu_op_type  op_q, next_op_q;          // Operation in flight.
    logic [2:0]  src_q, next_src_q;        // Source register index.
    logic [2:0]  dst_q, next_dst_q;        // Destination register index.
    logic [31:0] instr_q, next_instr_q;    // Last instruction word written.
    logic [6:0]  flags_q, next_flags_q;    // Status flags, software owned.
    logic        ill_q, next_ill_q;        // Sticky unknown opcode.
    logic        rd_ok, next_rd_ok;        // Read port held the bus address.
    logic [31:0] next_prdata;              // Next read data.
    logic        next_pready;              // Next ready.
    logic        next_pslverr;             // Next error.
    logic        acc;                      // Access phase.
    logic        commit;                   // Transfer completes this edge.
    logic        sel_instr;                // Instruction register selected.
    logic        sel_status;               // Status register selected.
    logic        sel_flags;                // Flags register selected.
    logic        sel_fp;                   // Floating-point register selected.
    logic        mapped;                   // Address is decoded.
    logic        busy;                     // Pipeline occupied.
    logic        we;                       // Register file write.
    logic [2:0]  waddr;                    // Register file write index.
    logic [31:0] wdata;                    // Register file write data.
    logic [2:0]  raddr;                    // Register file read index.
    logic [31:0] rdata;                    // Register file read data.
    logic [31:0] conv;                     // Conversion result.
    fcu_op_type  dec;                      // Decoded write data.

    fcu_regfile u_regs (
        .i_clk    (i_clk),
        .i_reset  (i_reset),
        .i_clk_en (i_clk_en),
        .i_we     (we),
        .i_waddr  (waddr),
        .i_wdata  (wdata),
        .i_raddr  (raddr),
        .o_rdata  (rdata)
    );

    fcu_convert u_conv (
        .i_op     (op_q),
        .i_src    (rdata),
        .o_result (conv)
    );

    // Address decode and register file port steering.
    always_comb begin
        acc = i_psel && i_penable;
        commit = acc && o_pready;
        sel_instr = (i_paddr == FCU_INSTR_OFS);
        sel_status = (i_paddr == FCU_STATUS_OFS);
        sel_flags = (i_paddr == FCU_FLAGS_OFS);
        sel_fp = ((i_paddr & FCU_FPREG_MASK) == FCU_FPREG_BASE) && (i_paddr[1:0] == 2'h0);
        mapped = sel_instr || sel_status || sel_flags || sel_fp;
        busy = (st != fcu_st_idle);
        dec = fcu_decode(i_pwdata);
        // The pipeline owns the read port in its read stage.
        raddr = (st == fcu_st_read) ? src_q : i_paddr[4:2];
        we = (st == fcu_st_write) || (commit && i_pwrite && sel_fp);
        waddr = (st == fcu_st_write) ? dst_q : i_paddr[4:2];
        wdata = (st == fcu_st_write) ? conv : i_pwdata;
    end

    // Bus answer: one wait state, longer while the pipeline is busy.
    always_comb begin
        next_rd_ok = i_psel && (st != fcu_st_read) && !we;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = o_prdata;
        // Status answers even while busy so software can poll busy; the rest wait
        // so the delay-slot hazard cannot reach the register file.
        if (acc && !o_pready && (sel_status || (!busy && rd_ok))) begin
            next_pready = 1'b1;
            next_pslverr = !mapped;
            next_prdata = '0;
            if (!i_pwrite) begin
                if (sel_instr) begin
                    next_prdata = instr_q;
                end else if (sel_status) begin
                    next_prdata[FCU_ST_BUSY_BIT] = busy;
                    next_prdata[FCU_ST_ILL_BIT] = ill_q;
                end else if (sel_flags) begin
                    next_prdata[FCU_FLAGS_W-1:0] = flags_q;
                end else if (sel_fp) begin
                    next_prdata = rdata;
                end
            end
        end
    end

    // Register writes, instruction issue and pipeline stepping.
    always_comb begin
        next_st = st;
        next_op_q = op_q;
        next_src_q = src_q;
        next_dst_q = dst_q;
        next_instr_q = instr_q;
        next_flags_q = flags_q;
        next_ill_q = ill_q;
        unique case (st)
            fcu_st_idle: next_st = fcu_st_idle;
            fcu_st_read: next_st = fcu_st_write;
            fcu_st_write: next_st = fcu_st_idle;
        endcase
        // Only software writes the flags; conversions leave them.
        if (commit && i_pwrite && sel_flags) begin
            next_flags_q = i_pwdata[FCU_FLAGS_W-1:0];
        end
        // Writing one clears the sticky bit; a new set below wins.
        if (commit && i_pwrite && sel_status && i_pwdata[FCU_ST_ILL_BIT]) begin
            next_ill_q = 1'b0;
        end
        if (commit && i_pwrite && sel_instr) begin
            next_instr_q = i_pwdata;
            if (dec == fcu_op_none) begin
                next_ill_q = 1'b1;
            end else begin
                next_st = fcu_st_read;
                next_op_q = dec;
                next_src_q = i_pwdata[16 + FCU_MSW_SRC_LSB +: FCU_RIW];
                next_dst_q = i_pwdata[16 + FCU_MSW_DST_LSB +: FCU_RIW];
            end
        end
    end

    // Registers all control state; a low enable freezes everything.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st <= fcu_st_idle;
            op_q <= fcu_op_none;
            src_q <= 3'h0;
            dst_q <= 3'h0;
            instr_q <= FCU_WORD_RST;
            flags_q <= FCU_FLAGS_RST;
            ill_q <= 1'b0;
            rd_ok <= 1'b0;
            o_prdata <= FCU_WORD_RST;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else if (i_clk_en) begin
            st <= next_st;
            op_q <= next_op_q;
            src_q <= next_src_q;
            dst_q <= next_dst_q;
            instr_q <= next_instr_q;
            flags_q <= next_flags_q;
            ill_q <= next_ill_q;
            rd_ok <= next_rd_ok;
            o_prdata <= next_prdata;
            o_pready <= next_pready;
            o_pslverr <= next_pslverr;
        end
    end

    // Helpers for the checks: tie detection and write-stage qualifiers.
    logic [46:0] tie_w;  // Source mantissa aligned at the binary point.
    logic        tie;    // Source lies exactly halfway, below 16384.
    logic        wr_st;  // Pipeline write stage.
    always_comb begin
        tie_w = 47'({1'b1, rdata[22:0]}) << (rdata[30:23] - FCU_EXP_BIAS);
        tie = (rdata[30:23] >= FCU_EXP_BIAS) && (rdata[30:23] < 8'h8d)
            && (tie_w[22:0] == 23'h40_0000);
        wr_st = (st == fcu_st_write);
    end

    decode_round_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_st && op_q == float_to_s16_round_op) |->
        (instr_q[15:0] == FCU_LSW_S16 && instr_q[16 + FCU_MSW_RND_BIT]))
        else $error("round op issued from wrong word");
    tie_even_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_st && tie && (op_q == float_to_s16_round_op || op_q == float_to_u16_round_op)
         && !rdata[31]) |-> (we && !wdata[0]))
        else $error("tie not rounded to even");
    sign_extend_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_st && (op_q == float_to_s16_round_op || op_q == float_to_s16_trunc_op)) |->
        (wdata[31:16] == {16{wdata[15]}}))
        else $error("16-bit result not sign extended");
    s32_sign_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_st && op_q == float_to_s32_trunc_op && rdata[30:23] >= FCU_EXP_BIAS) |->
        (wdata[31] == rdata[31] && wdata != 32'h0))
        else $error("32-bit result sign wrong");
    u16_upper_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_st && op_q == float_to_u16_trunc_op) |-> (wdata[31:16] == 16'h0000))
        else $error("unsigned truncation upper half set");
    u16r_upper_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_st && op_q == float_to_u16_round_op) |-> (wdata[31:16] == 16'h0000))
        else $error("unsigned rounding upper half set");
    u32_exact_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_st && op_q == float_to_u32_op && !rdata[31] && rdata[30:23] == FCU_EXP_INT) |->
        (wdata == {9'h001, rdata[22:0]} && wdata[23]))
        else $error("unsigned 32-bit value wrong");
    frac_small_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_st && op_q == fraction_extract_op) |-> (wdata[30:23] < FCU_EXP_BIAS))
        else $error("fraction not below one");
    i2f_sign_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_st && op_q == s16_to_float_op && rdata[15:0] != 16'h0) |->
        (wdata[31] == rdata[15] && wdata[30:23] >= FCU_EXP_BIAS))
        else $error("integer to float sign wrong");
    dest_index_a: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_st |-> (we && waddr == instr_q[16 + FCU_MSW_DST_LSB +: FCU_RIW]))
        else $error("wrong destination register");
    flags_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !(commit && i_pwrite && sel_flags) |=> $stable(flags_q))
        else $error("flags changed by conversion");
    issue_lat_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (st == fcu_st_read && i_clk_en) ##1 (i_clk_en [*1]) |-> wr_st ##1 (st == fcu_st_idle))
        else $error("pipeline latency wrong");
    neg_unsigned_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_st && rdata[31] && (op_q == float_to_u32_op || op_q == float_to_u16_trunc_op
         || op_q == float_to_u16_round_op)) |-> (wdata == 32'h0))
        else $error("negative unsigned not zero");
    round_run_c: cover property (@(posedge i_clk) disable iff (i_reset)
        wr_st && op_q == float_to_s16_round_op && tie);
    frac_run_c: cover property (@(posedge i_clk) disable iff (i_reset)
        wr_st && op_q == fraction_extract_op);
    i2f_run_c: cover property (@(posedge i_clk) disable iff (i_reset)
        wr_st && op_q == s16_to_float_op && rdata[15]);
    stall_c: cover property (@(posedge i_clk) disable iff (i_reset)
        acc && busy && !o_pready ##PIPE_LAT o_pready);
endmodule // fcu_top
`default_nettype wire

// *** verif/fcu_host.sv ***
/* Host issue model: an APB master that writes words and reads registers.
   Assumes each call starts in step with the unit's clock. */
`timescale 1ns/1ns
`default_nettype none
module fcu_host (
    // Clock and answer.
    input  wire logic        i_clk,
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr,
    // Request.
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [7:0]       o_paddr,
    output logic [31:0]      o_pwdata
);
    logic last_err; // Error flag that came with the last answer.
    // The bus idles from time zero.
    initial begin
        last_err = 1'b0;
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0000_0000;
    end
    // Each transfer waits for its answer, so nothing lands in a delay slot.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge i_clk);
        o_psel <= 1'b1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clk);
        o_penable <= 1'b1;
        do @(posedge i_clk); while (i_pready !== 1'b1);
        r = i_prdata;
        last_err = i_pslverr;
        // Released lines change, so a stale value is never mistaken for a request.
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_paddr <= ~a;
        o_pwdata <= ~d;
    endtask
endmodule // fcu_host
`default_nettype wire

// *** verif/tb_float_int_conversion_unit.sv ***
/* Bench of the conversion unit: flags reset value, every opcode, flags untouched.
   Assumes the host model stands on the APB side. */
`timescale 1ns/1ns
`default_nettype none
module tb_float_int_conversion_unit
    import fcu_pkg::*;
;
    logic        i_clk = 1'b0;
    logic        clk_en = 1'b1;
    logic        i_reset = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          n = 0;
    fcu_top i_fcu_top (.i_clk(i_clk), .i_reset(i_reset), .i_clk_en(clk_en), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
    fcu_host i_fcu_host (.i_clk(i_clk), .i_prdata(prdata), .i_pready(pready),
        .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata));
    // A 50 ns clock.
    always #25 i_clk = ~i_clk;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Loads a source, issues the word, reads the destination and the flags back.
    task automatic conv(input logic [15:0] lsw, input logic r, input logic [31:0] src,
                        input logic [31:0] exp);
        logic [2:0] s;
        logic [2:0] d;
        s = 3'(n);
        d = 3'(n + 3);
        n++;
        i_fcu_host.xfer(1'b1, FCU_FPREG_BASE + {3'h0, s, 2'h0}, src, rd);
        i_fcu_host.xfer(1'b1, FCU_INSTR_OFS, {r, 9'h000, s, d, lsw}, rd);
        i_fcu_host.xfer(1'b0, FCU_FPREG_BASE + {3'h0, d, 2'h0}, '0, rd);
        check(rd, exp);
        i_fcu_host.xfer(1'b0, FCU_FLAGS_OFS, '0, rd);
        check(rd, 32'h0000_0055);
    endtask
    // A hang ends the run as a failure.
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        i_fcu_host.xfer(1'b0, FCU_FLAGS_OFS, '0, rd);
        check(rd, 32'h0000_0000);
        i_fcu_host.xfer(1'b1, FCU_FLAGS_OFS, 32'h0000_0055, rd);
        $display("reset test done");
        conv(FCU_LSW_S16, 1'b1, 32'h3fd9999a, 32'h0000_0002);
        conv(FCU_LSW_S16, 1'b1, 32'hbfd9999a, 32'hffff_fffe);
        conv(FCU_LSW_S16, 1'b1, 32'h40200000, 32'h0000_0002);
        conv(FCU_LSW_S32, 1'b0, 32'hc0300000, 32'hffff_fffe);
        conv(FCU_LSW_U16, 1'b0, 32'h412ccccd, 32'h0000_000a);
        conv(FCU_LSW_U16, 1'b0, 32'hc1100000, 32'h0000_0000);
        conv(FCU_LSW_U16, 1'b1, 32'h412ccccd, 32'h0000_000b);
        conv(FCU_LSW_U16, 1'b1, 32'h40200000, 32'h0000_0002);
        conv(FCU_LSW_U32, 1'b0, 32'h41480000, 32'h0000_000c);
        conv(FCU_LSW_U32, 1'b0, 32'hc0d00000, 32'h0000_0000);
        conv(FCU_LSW_FRAC, 1'b0, 32'h419d0000, 32'h3f20_0000);
        conv(FCU_LSW_I2F, 1'b0, 32'h1234fffc, 32'hc080_0000);
        conv(FCU_LSW_S16, 1'b0, 32'hc0a00000, 32'hffff_fffb);
        conv(FCU_LSW_S32, 1'b0, 32'hcb2af5a5, 32'hff55_0a5b);
        conv(FCU_LSW_U32, 1'b0, 32'h4b2af5a5, 32'h00aa_f5a5);
        i_fcu_host.xfer(1'b1, FCU_INSTR_OFS, 32'h8000_e688, rd);
        i_fcu_host.xfer(1'b0, FCU_STATUS_OFS, '0, rd);
        check(rd, 32'h0000_0002);
        i_fcu_host.xfer(1'b0, FCU_FPREG_BASE + 8'h01, '0, rd);
        check(rd, 32'h0000_0000);
        check({31'h0, i_fcu_host.last_err}, 32'h0000_0001);
        // Freezing the enable mid-pipeline only stretches the conversion.
        i_fcu_host.xfer(1'b1, FCU_FPREG_BASE + 8'h1c, 32'hcb2af5a5, rd);
        i_fcu_host.xfer(1'b1, FCU_INSTR_OFS, {16'h0038, FCU_LSW_S32}, rd);
        clk_en <= 1'b0;
        repeat (3) @(posedge i_clk);
        clk_en <= 1'b1;
        i_fcu_host.xfer(1'b0, FCU_FPREG_BASE, '0, rd);
        check(rd, 32'hff55_0a5b);
        check({31'h0, i_fcu_host.last_err}, 32'h0000_0000);
        $display("opcode test done");
        end_of_test();
    end
endmodule // tb_float_int_conversion_unit
`default_nettype wire
